//--- design/pkau_pkg.sv
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pkau_pkg;

  localparam int DIG_W = 16;
  localparam int IDX_W = 6;
  localparam int SUB_W = 2;
  localparam int CNT_W = 4;
  localparam int WORDS = 64;
  localparam int MEMS = 4;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_START = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0c;
  localparam logic [7:0] OFF_INT_MASK = 8'h10;
  localparam logic [7:0] OFF_MEM_ADDR = 8'h14;
  localparam logic [7:0] OFF_MEM_DATA = 8'h18;

  localparam int CTRL_FIRST_LSB = 0;
  localparam int CTRL_SECOND_LSB = 2;
  localparam int CTRL_MOD_LSB = 4;
  localparam int CTRL_SIZE_LSB = 8;
  localparam int CTRL_RESIDUE_BIT = 12;
  localparam int CTRL_SWRST_BIT = 31;
  localparam logic [12:0] CTRL_RST = 13'h0300;

  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_BAD_BIT = 1;
  localparam logic [1:0] INT_RST = 2'h0;

  localparam int MADDR_MEM_LSB = 6;

  localparam logic [11:0] ENTRY_ADD = 12'h008;
  localparam logic [11:0] ENTRY_SUB = 12'h009;
  localparam logic [11:0] ENTRY_CLEAR = 12'h00d;

  localparam logic [1:0] MEM_A = 2'h0;
  localparam logic [1:0] MEM_B = 2'h1;
  localparam logic [1:0] MEM_N = 2'h2;
  localparam logic [1:0] MEM_T = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CLEAR = 2'b01,
    ST_RUN = 2'b10,
    ST_COPY = 2'b11
  } pkau_state_e;

endpackage

//--- design/pkau_add_sub_clear.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pkau_add_sub_clear
  import pkau_pkg::*;
(
  input wire logic mclk, // 20 MHz clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic irq // Level interrupt.
);

  //----------------------------------------------------------------------------
  // Decoding
  //----------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_START) ||
                (a == OFF_INT_STAT) || (a == OFF_INT_MASK) ||
                (a == OFF_MEM_ADDR) || (a == OFF_MEM_DATA);
  endfunction

  function automatic logic [IDX_W-1:0] word_at(input logic [SUB_W-1:0] s,
                                                input logic [CNT_W-1:0] d);
    word_at = {s, d};
  endfunction

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  logic [DIG_W-1:0] ram [MEMS][WORDS];
  pkau_state_e state_r, state_nxt;
  logic [IDX_W-1:0] cnt_r, cnt_nxt;
  logic c_r, c_nxt, k_r, k_nxt;
  logic op_sub_r, op_sub_nxt;
  logic pick_hi_r, pick_hi_nxt;
  logic done_r, done_nxt;
  logic [12:0] ctrl_r, ctrl_nxt;
  logic [1:0] int_stat_r, int_stat_nxt;
  logic [1:0] int_mask_r, int_mask_nxt;
  logic [7:0] maddr_r, maddr_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  logic wr, rd_setup, soft_rst, start_wr, fin;
  logic [11:0] entry;
  logic [SUB_W-1:0] sel_a, sel_b, sel_n;
  logic [CNT_W-1:0] modsize, dig;
  logic [DIG_W-1:0] a_d, b_d, n_d, t0_d, t1_d, copy_d;
  logic [DIG_W:0] s17, d17;
  logic [31:0] rd_mux;
  logic clr_we, t_we, b_we, host_we;
  logic last_dig;

  assign sel_a = ctrl_r[CTRL_FIRST_LSB +: SUB_W];
  assign sel_b = ctrl_r[CTRL_SECOND_LSB +: SUB_W];
  assign sel_n = ctrl_r[CTRL_MOD_LSB +: SUB_W];
  assign modsize = ctrl_r[CTRL_SIZE_LSB +: CNT_W];
  assign dig = cnt_r[CNT_W-1:0];
  assign last_dig = (dig == modsize);

  //----------------------------------------------------------------------------
  // APB slave
  //----------------------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign prdata = prdata_r;
  assign wr = psel & penable & pwrite & is_mapped(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign soft_rst = wr && (paddr == OFF_CTRL) && pwdata[CTRL_SWRST_BIT];
  assign start_wr = wr && (paddr == OFF_START) && (state_r == ST_IDLE);
  assign entry = pwdata[11:0];
  assign irq = |(int_stat_r & int_mask_r);

  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      OFF_CTRL: rd_mux = {19'h0, ctrl_r};
      OFF_STATUS: rd_mux = {30'h0, state_r != ST_IDLE, done_r};
      OFF_INT_STAT: rd_mux = {30'h0, int_stat_r};
      OFF_INT_MASK: rd_mux = {30'h0, int_mask_r};
      OFF_MEM_ADDR: rd_mux = {24'h0, maddr_r};
      OFF_MEM_DATA: rd_mux = {16'h0, ram[maddr_r[7:6]][maddr_r[5:0]]};
      default: rd_mux = 32'h0;
    endcase
  end

  //----------------------------------------------------------------------------
  // Digit datapath
  //----------------------------------------------------------------------------
  assign a_d = ram[MEM_A][word_at(sel_a, dig)];
  assign b_d = ram[MEM_B][word_at(sel_b, dig)];
  assign n_d = ram[MEM_N][word_at(sel_n, dig)];

  // The residue mode bit is never read here, so both forms share one path.
  always_comb begin
    if (op_sub_r) begin
      s17 = {1'b0, a_d} - {1'b0, b_d} - {16'h0, c_r};
      d17 = {1'b0, s17[DIG_W-1:0]} + {1'b0, n_d} + {16'h0, k_r};
    end else begin
      s17 = {1'b0, a_d} + {1'b0, b_d} + {16'h0, c_r};
      d17 = {1'b0, s17[DIG_W-1:0]} - {1'b0, n_d} - {16'h0, k_r};
    end
  end

  assign t0_d = s17[DIG_W-1:0];
  assign t1_d = d17[DIG_W-1:0];
  assign copy_d = ram[MEM_T][word_at({1'b0, pick_hi_r}, dig)];

  //----------------------------------------------------------------------------
  // Sequencer and registers
  //----------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    c_nxt = c_r;
    k_nxt = k_r;
    op_sub_nxt = op_sub_r;
    pick_hi_nxt = pick_hi_r;
    done_nxt = done_r;
    ctrl_nxt = ctrl_r;
    int_stat_nxt = int_stat_r;
    int_mask_nxt = int_mask_r;
    maddr_nxt = maddr_r;
    prdata_nxt = rd_setup ? rd_mux : prdata_r;
    clr_we = 1'b0;
    t_we = 1'b0;
    b_we = 1'b0;
    host_we = 1'b0;
    fin = 1'b0;
    if (wr && paddr == OFF_CTRL) ctrl_nxt = pwdata[12:0];
    if (wr && paddr == OFF_INT_MASK) int_mask_nxt = pwdata[1:0];
    if (wr && paddr == OFF_MEM_ADDR) maddr_nxt = pwdata[7:0];
    if (wr && paddr == OFF_INT_STAT) int_stat_nxt = int_stat_r & ~pwdata[1:0];
    if (wr && paddr == OFF_MEM_DATA && state_r == ST_IDLE) host_we = 1'b1;
    unique case (state_r)
      ST_IDLE: begin
        if (start_wr) begin
          cnt_nxt = '0;
          c_nxt = 1'b0;
          k_nxt = 1'b0;
          if (entry == ENTRY_ADD || entry == ENTRY_SUB) begin
            state_nxt = ST_RUN;
            op_sub_nxt = (entry == ENTRY_SUB);
            done_nxt = 1'b0;
          end else if (entry == ENTRY_CLEAR) begin
            state_nxt = ST_CLEAR;
            done_nxt = 1'b0;
          end else begin
            int_stat_nxt[INT_BAD_BIT] = 1'b1;
          end
        end
      end
      ST_CLEAR: begin
        clr_we = 1'b1;
        cnt_nxt = cnt_r + 6'h1;
        if (cnt_r == 6'h3f) begin
          state_nxt = ST_IDLE;
          fin = 1'b1;
        end
      end
      ST_RUN: begin
        t_we = 1'b1;
        c_nxt = s17[DIG_W];
        k_nxt = d17[DIG_W];
        cnt_nxt = cnt_r + 6'h1;
        if (last_dig) begin
          // Sub: wrap when A<B. Add: reduce when the sum reaches N.
          pick_hi_nxt = op_sub_r ? s17[DIG_W] : (s17[DIG_W] | ~d17[DIG_W]);
          cnt_nxt = '0;
          state_nxt = ST_COPY;
        end
      end
      ST_COPY: begin
        b_we = 1'b1;
        cnt_nxt = cnt_r + 6'h1;
        if (last_dig) begin
          cnt_nxt = '0;
          state_nxt = ST_IDLE;
          fin = 1'b1;
        end
      end
    endcase
    if (fin) begin
      done_nxt = 1'b1;
      int_stat_nxt[INT_DONE_BIT] = 1'b1;
    end
    if (soft_rst) begin
      state_nxt = ST_CLEAR;
      cnt_nxt = '0;
      done_nxt = 1'b0;
      ctrl_nxt = CTRL_RST;
      int_stat_nxt = INT_RST;
      int_mask_nxt = INT_RST;
      maddr_nxt = 8'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_CLEAR;
      cnt_r <= '0;
      c_r <= 1'b0;
      k_r <= 1'b0;
      op_sub_r <= 1'b0;
      pick_hi_r <= 1'b0;
      done_r <= 1'b0;
      ctrl_r <= CTRL_RST;
      int_stat_r <= INT_RST;
      int_mask_r <= INT_RST;
      maddr_r <= 8'h0;
      prdata_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      c_r <= c_nxt;
      k_r <= k_nxt;
      op_sub_r <= op_sub_nxt;
      pick_hi_r <= pick_hi_nxt;
      done_r <= done_nxt;
      ctrl_r <= ctrl_nxt;
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      maddr_r <= maddr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Operand memories
  //----------------------------------------------------------------------------
  // The memories carry no reset; the clear routine zeroes them after each reset.
  always_ff @(posedge mclk) begin
    if (clr_we) begin
      for (int m = 0; m < MEMS; m++) begin
        ram[m][cnt_r] <= '0;
      end
    end else begin
      if (t_we) begin
        ram[MEM_T][word_at(2'h0, dig)] <= t0_d;
        ram[MEM_T][word_at(2'h1, dig)] <= t1_d;
      end
      if (b_we) ram[MEM_B][word_at(sel_b, dig)] <= copy_d;
      if (host_we) ram[maddr_r[7:6]][maddr_r[5:0]] <= pwdata[DIG_W-1:0];
    end
  end

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_start_add;
    start_wr && entry == ENTRY_ADD;
  endsequence

  sequence s_start_sub;
    start_wr && entry == ENTRY_SUB;
  endsequence

  a_add_entry_runs: assert property (s_start_add |=> state_r == ST_RUN && !op_sub_r)
    else $error("add entry did not start an addition");

  a_sub_entry_runs: assert property (s_start_sub |=> state_r == ST_RUN && op_sub_r)
    else $error("subtract entry did not start a subtraction");

  a_sub_wrap_pick: assert property (state_r == ST_RUN && last_dig && op_sub_r && s17[DIG_W]
    |=> pick_hi_r)
    else $error("subtract with A below B did not add the modulus");

  a_result_to_b: assert property (b_we |=>
    ram[MEM_B][$past(word_at(sel_b, dig))] == $past(copy_d))
    else $error("result digit not written into the B sub-register");

  a_clear_zeroes: assert property (clr_we |=> ram[MEM_N][$past(cnt_r)] == 16'h0 &&
    ram[MEM_A][$past(cnt_r)] == 16'h0 && ram[MEM_B][$past(cnt_r)] == 16'h0 &&
    ram[MEM_T][$past(cnt_r)] == 16'h0)
    else $error("clear routine left a nonzero word");

  a_clear_keeps_regs: assert property (state_r == ST_CLEAR && !wr |=> $stable(ctrl_r))
    else $error("clear routine altered a control register");

  a_soft_reset_clears: assert property (soft_rst |=> state_r == ST_CLEAR && cnt_r == 6'h0)
    else $error("software reset did not start the memory clear");

  a_done_after_clear: assert property (state_r == ST_CLEAR |-> !done_r)
    else $error("done rose before the memory clear finished");

  a_digit_count: assert property ($rose(state_r == ST_RUN) && modsize == 4'h3
    |-> (state_r == ST_RUN) [*4] ##1 state_r == ST_COPY)
    else $error("run phase length differs from digit count");

  a_done_on_finish: assert property (state_r == ST_COPY && last_dig && !soft_rst
    |=> done_r && int_stat_r[INT_DONE_BIT])
    else $error("done not raised at routine completion");

endmodule
`default_nettype wire

//--- verif/pkau_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side of the register bus.
// ----------------------------------------
module pkau_host_model (
  input wire logic mclk, // Clock.
  output logic psel, // Select.
  output logic penable, // Enable.
  output logic pwrite, // Direction.
  output logic [7:0] paddr, // Byte address.
  output logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr // Error response.
);
  logic err;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err = 1'b0;
  end
  // Released address and data are inverted so stale values never look valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- verif/test_modular_add_sub_clear.sv
`timescale 1ns/1ps
`default_nettype none
module test_modular_add_sub_clear;
  import pkau_pkg::*;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, sub;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [271:0] va, vb, vn, ve;
  int errors, total_checks, ms, sa, sb, sn;
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  pkau_add_sub_clear pkau_add_sub_clear_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  pkau_host_model pkau_host_model_i (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // ----------------------------------------
  // Bus access, checking and reference arithmetic.
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    pkau_host_model_i.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a);
    pkau_host_model_i.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_done();
    q = 32'h0;
    for (int n = 0; n < 300 && q[STAT_DONE_BIT] !== 1'b1; n++) rd(OFF_STATUS);
    chk(q & 32'h3, 32'h1);
  endtask
  task automatic put(input logic [1:0] m, input int s, input logic [271:0] v);
    for (int i = 0; i <= ms; i++) begin
      wr(OFF_MEM_ADDR, {24'h0, m, s[1:0], i[3:0]});
      wr(OFF_MEM_DATA, {16'h0, v[i*16 +: 16]});
    end
  endtask
  function automatic logic [271:0] rnd();
    logic [271:0] r;
    for (int i = 0; i < 17; i++) r[i*16 +: 16] = 16'($urandom);
    return r;
  endfunction
  function automatic logic [271:0] expect_of(input logic s);
    if (s)
      return (va >= vb) ? va - vb : va - vb + vn;
    return (va + vb >= vn) ? va + vb - vn : va + vb;
  endfunction
  task automatic run_op(input logic res);
    put(MEM_A, sa, va);
    put(MEM_B, sb, vb);
    put(MEM_N, sn, vn);
    wr(OFF_CTRL, {19'h0, res, ms[3:0], 2'h0, sn[1:0], sb[1:0], sa[1:0]});
    wr(OFF_START, {20'h0, sub ? ENTRY_SUB : ENTRY_ADD});
    wait_done();
    ve = expect_of(sub);
    for (int i = 0; i <= ms; i++) begin
      wr(OFF_MEM_ADDR, {24'h0, MEM_B, sb[1:0], i[3:0]});
      rd(OFF_MEM_DATA);
      chk(q, {16'h0, ve[i*16 +: 16]});
    end
  endtask
  initial begin
    #2_000_000;
    errors++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    errors = 0;
    total_checks = 0;
    sa = $urandom(32'hf621);
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFF_STATUS);
    chk(q & 32'h3, 32'h2);
    wait_done();
    $display("test reset done");
    for (int w = 0; w < 256; w++) begin
      wr(OFF_MEM_ADDR, w);
      wr(OFF_MEM_DATA, {16'h0, 16'($urandom) | 16'h1});
    end
    wr(OFF_CTRL, 32'h0000_1f36);
    wr(OFF_START, {20'h0, ENTRY_CLEAR});
    wait_done();
    for (int w = 0; w < 256; w++) begin
      wr(OFF_MEM_ADDR, w);
      rd(OFF_MEM_DATA);
      chk(q, 32'h0);
    end
    rd(OFF_CTRL);
    chk(q, 32'h0000_1f36);
    $display("test clear done");
    wr(OFF_CTRL, 32'h8000_0000);
    rd(OFF_STATUS);
    chk(q & 32'h3, 32'h2);
    wait_done();
    rd(OFF_CTRL);
    chk(q, 32'h0000_0300);
    $display("test soft reset done");
    for (int k = 0; k < 20; k++) begin
      sub = k[0];
      ms = (k < 2) ? 3 : (k < 4) ? 15 : 3 + $urandom % 13;
      sa = $urandom % 4;
      sb = $urandom % 4;
      sn = $urandom % 4;
      vn = rnd() & ((272'h1 << (16 * (ms + 1))) - 1);
      vn[16*ms+15] = 1'b1;
      va = (k < 2) ? vn - 1 : (k < 4) ? 272'h0 : rnd() % vn;
      vb = (k < 4) ? vn - 1 : rnd() % vn;
      run_op(1'($urandom % 2));
    end
    $display("test arithmetic done");
    wr(OFF_INT_MASK, 32'h1);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_INT_STAT, 32'h1);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_START, 32'h0000_07ff);
    rd(OFF_INT_STAT);
    chk(q, 32'h2);
    rd(8'h40);
    chk({31'h0, pkau_host_model_i.err}, 32'h1);
    $display("test interrupt done");
    close_out();
  end
endmodule
`default_nettype wire
